// ### common/plam_pkg.sv
// Package of constants for the part life alarm monitor
package plam_pkg;
   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] OFF_STATUS      = 8'h00;
   localparam logic [7:0] OFF_INRUSH      = 8'h04;
   localparam logic [7:0] OFF_CTRL_CAP    = 8'h08;
   localparam logic [7:0] OFF_MAIN_CAP    = 8'h0c;
   localparam logic [7:0] OFF_MEAS_STATE  = 8'h10;
   localparam logic [7:0] OFF_TERM_SEL_A  = 8'h14;
   localparam logic [7:0] OFF_TERM_SEL_B  = 8'h18;
   localparam logic [7:0] OFF_TERM_SEL_C  = 8'h1c;
   localparam logic [7:0] OFF_INRUSH_CNT  = 8'h20;
   localparam logic [7:0] OFF_IRQ_STATUS  = 8'h24;
   localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h28;
   localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h2c;
   // Status bit positions
   localparam int BIT_CTRL_CAP = 0;
   localparam int BIT_MAIN_CAP = 1;
   localparam int BIT_FAN      = 2;
   localparam int BIT_INRUSH   = 3;
   // Interrupt event bit positions
   localparam int EV_ALARM     = 0;
   localparam int EV_MEAS_DONE = 1;
   localparam int EV_MEAS_BAD  = 2;
   // Terminal function codes
   localparam logic [7:0] SEL_POS = 8'h5a;   // 90
   localparam logic [7:0] SEL_NEG = 8'hbe;   // 190
   // Life figures in percent
   localparam logic [6:0] PCT_FULL       = 7'h64;  // 100
   localparam logic [6:0] PCT_INRUSH_AL  = 7'h0a;  // 10
   localparam logic [6:0] PCT_CTRL_AL    = 7'h0a;  // 10
   localparam logic [6:0] PCT_MAIN_AL    = 7'h55;  // 85
   localparam logic [13:0] INRUSH_PER_PCT = 14'h2710; // 10,000
   // Measurement state codes
   localparam logic [3:0] MS_IDLE  = 4'h0;
   localparam logic [3:0] MS_START = 4'h1;
   localparam logic [3:0] MS_MEAS  = 4'h2;
   localparam logic [3:0] MS_DONE  = 4'h3;
   localparam logic [3:0] MS_FORCE = 4'h8;
   localparam logic [3:0] MS_ERROR = 4'h9;
   // DC injection time
   localparam int CLK_HZ       = 200000000;
   localparam int DC_TIME_MS   = 1000;
   localparam int DC_CYCLES    = (CLK_HZ / 1000) * DC_TIME_MS;
   // Reset values
   localparam logic [7:0] TERM_SEL_RST = 8'h00;
   localparam logic [2:0] IRQ_EN_RST   = 3'h0;
   // Internal state machine, Gray along idle-start-measuring-done
   typedef enum logic [2:0]
   {
      PLAM_ST_IDLE  = 3'b000,
      PLAM_ST_START = 3'b001,
      PLAM_ST_MEAS  = 3'b011,
      PLAM_ST_DONE  = 3'b010,
      PLAM_ST_FORCE = 3'b110,
      PLAM_ST_ERROR = 3'b111
   } plam_state_t;
endpackage : plam_pkg

// ### hdl/plam_monitor.sv
// Part life alarm monitor with Avalon-MM register slave
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module plam_monitor
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Inverter events, one-cycle pulses
   input  wire logic        power_on_event,
   input  wire logic        undervoltage_event,
   input  wire logic        inverter_reset_event,
   input  wire logic        power_off_event,
   // Inverter conditions, levels
   input  wire logic        operating,
   input  wire logic        run_command,
   input  wire logic        output_shutoff_input,
   input  wire logic        trip_active,
   input  wire logic        motor_ok,
   // Control capacitor wear tick from the thermal model
   input  wire logic        ctrl_cap_wear_tick,
   // Main capacitor measurement result
   input  wire logic        cap_result_valid,
   input  wire logic [6:0]  cap_result_percent,
   // Fan speed in percent of nominal
   input  wire logic [6:0]  fan_speed_percent,
   // Outputs
   output logic             life_alarm_output,
   output logic             fan_fault_indication,
   output logic             dc_inject,
   output logic [2:0]       output_terminals,
   output logic             irq
);

   plam_pkg::plam_state_t state_reg;
   logic [19:0] inrush_cnt_reg;
   logic [13:0] inrush_sub_reg;
   logic [6:0]  inrush_life_percent;
   logic [6:0]  control_cap_life_percent;
   logic [6:0]  main_cap_life_percent;
   logic [3:0]  life_alarm_status;
   logic [7:0]  output_terminal_select_a;
   logic [7:0]  output_terminal_select_b;
   logic [7:0]  output_terminal_select_c;
   // 28 bits hold one second at 200 MHz; a clock above 268 MHz needs more
   logic [27:0] dc_cnt_reg;
   logic [2:0]  irq_status_reg;
   logic [2:0]  irq_enable_reg;
   logic [2:0]  irq_event;
   logic [3:0]  capacitor_measure_state;
   logic        wr_acc;
   logic        rd_acc;
   logic        rd_pending_reg;
   logic        inrush_hit;
   logic [2:0]  term_pos;
   logic [2:0]  term_neg;
   logic [7:0]  wdata_b0;
   logic        alarm_prev_reg;
   logic        meas_wr;
   logic        meas_restart;
   logic        meas_done;

   // One wait cycle on reads so read data comes from a register
   assign wr_acc          = avs_write;
   assign rd_acc          = avs_read && rd_pending_reg;
   assign avs_waitrequest = avs_read && !rd_pending_reg;
   assign wdata_b0        = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         rd_pending_reg <= 1'b0;
      else
         // Clears on the completing edge so back-to-back reads each wait once
         rd_pending_reg <= avs_read && !rd_acc;
   end

   // Inrush counter; simultaneous sources still count once per cycle
   assign inrush_hit = power_on_event || undervoltage_event || inverter_reset_event;

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         inrush_cnt_reg      <= 20'h00000;
         inrush_sub_reg      <= 14'h0000;
         inrush_life_percent <= plam_pkg::PCT_FULL;
      end
      else if (inrush_hit)
      begin
         // Count holds at full scale rather than wrap
         if (inrush_cnt_reg != 20'hfffff)
            inrush_cnt_reg <= inrush_cnt_reg + 20'h00001;
         if (inrush_sub_reg == plam_pkg::INRUSH_PER_PCT - 14'h0001)
         begin
            inrush_sub_reg <= 14'h0000;
            if (inrush_life_percent != 7'h00)
               inrush_life_percent <= inrush_life_percent - 7'h01;
         end
         else
            inrush_sub_reg <= inrush_sub_reg + 14'h0001;
      end
   end

   // Control capacitor wear; tick rate is set by the external thermal model
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         control_cap_life_percent <= plam_pkg::PCT_FULL;
      else if (operating && ctrl_cap_wear_tick && control_cap_life_percent != 7'h00)
         control_cap_life_percent <= control_cap_life_percent - 7'h01;
   end

   // Measure-state writes use byte lane 0 only
   assign meas_wr      = wr_acc && (avs_address == plam_pkg::OFF_MEAS_STATE) &&
                         avs_byteenable[0];
   assign meas_restart = meas_wr && (wdata_b0[3:0] == plam_pkg::MS_START);

   // Done needs the injection over and no cause that ends the run otherwise
   assign meas_done = (state_reg == plam_pkg::PLAM_ST_MEAS) &&
                      (dc_cnt_reg == 28'h0000000) &&
                      cap_result_valid &&
                      !meas_restart &&
                      !run_command &&
                      !output_shutoff_input &&
                      !power_on_event;

   // Main capacitor life only moves on a completed measurement
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         main_cap_life_percent <= plam_pkg::PCT_FULL;
      else if (meas_done)
         main_cap_life_percent <= (cap_result_percent > plam_pkg::PCT_FULL) ?
                                  plam_pkg::PCT_FULL : cap_result_percent;
   end

   // Measurement state machine
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         state_reg  <= plam_pkg::PLAM_ST_IDLE;
         dc_cnt_reg <= 28'h0000000;
      end
      else
      begin
         case (state_reg)
            plam_pkg::PLAM_ST_IDLE, plam_pkg::PLAM_ST_DONE,
            plam_pkg::PLAM_ST_FORCE, plam_pkg::PLAM_ST_ERROR:
            begin
               // Only 0 and 1 are writable; 3 and 8 writes fall through
               if (wr_acc && avs_address == plam_pkg::OFF_MEAS_STATE && avs_byteenable[0])
               begin
                  if (wdata_b0[3:0] == plam_pkg::MS_START)
                     state_reg <= plam_pkg::PLAM_ST_START;
                  else if (wdata_b0[3:0] == plam_pkg::MS_IDLE)
                     state_reg <= plam_pkg::PLAM_ST_IDLE;
               end
            end
            plam_pkg::PLAM_ST_START:
            begin
               if (wr_acc && avs_address == plam_pkg::OFF_MEAS_STATE && avs_byteenable[0]
                   && wdata_b0[3:0] == plam_pkg::MS_IDLE)
                  state_reg <= plam_pkg::PLAM_ST_IDLE;
               else if (power_off_event)
               begin
                  // Trip at power-off stays in 1 so no DC is applied
                  if (!trip_active)
                  begin
                     state_reg  <= plam_pkg::PLAM_ST_MEAS;
                     dc_cnt_reg <= 28'(plam_pkg::DC_CYCLES);
                  end
               end
            end
            plam_pkg::PLAM_ST_MEAS:
            begin
               if (wr_acc && avs_address == plam_pkg::OFF_MEAS_STATE && avs_byteenable[0]
                   && wdata_b0[3:0] == plam_pkg::MS_START)
               begin
                  state_reg  <= plam_pkg::PLAM_ST_START;
                  dc_cnt_reg <= 28'h0000000;
               end
               else if (run_command || output_shutoff_input)
               begin
                  state_reg  <= plam_pkg::PLAM_ST_FORCE;
                  dc_cnt_reg <= 28'h0000000;
               end
               else if (power_on_event && dc_cnt_reg != 28'h0000000)
               begin
                  // Power back while injecting: abort, stay reported as 2
                  dc_cnt_reg <= 28'h0000000;
               end
               else if (dc_cnt_reg != 28'h0000000)
               begin
                  if (!motor_ok)
                  begin
                     state_reg  <= plam_pkg::PLAM_ST_ERROR;
                     dc_cnt_reg <= 28'h0000000;
                  end
                  else
                     dc_cnt_reg <= dc_cnt_reg - 28'h0000001;
               end
               else if (meas_done)
                  state_reg <= plam_pkg::PLAM_ST_DONE;
            end
            default:
               state_reg <= plam_pkg::PLAM_ST_IDLE;
         endcase
      end
   end

   assign dc_inject = (state_reg == plam_pkg::PLAM_ST_MEAS) && (dc_cnt_reg != 28'h0000000);

   always_comb
   begin
      case (state_reg)
         plam_pkg::PLAM_ST_IDLE:  capacitor_measure_state = plam_pkg::MS_IDLE;
         plam_pkg::PLAM_ST_START: capacitor_measure_state = plam_pkg::MS_START;
         plam_pkg::PLAM_ST_MEAS:  capacitor_measure_state = plam_pkg::MS_MEAS;
         plam_pkg::PLAM_ST_DONE:  capacitor_measure_state = plam_pkg::MS_DONE;
         plam_pkg::PLAM_ST_FORCE: capacitor_measure_state = plam_pkg::MS_FORCE;
         plam_pkg::PLAM_ST_ERROR: capacitor_measure_state = plam_pkg::MS_ERROR;
         default:                 capacitor_measure_state = plam_pkg::MS_IDLE;
      endcase
   end

   // Status bits follow the life figures and the registered fan flag directly
   // Not sticky: a fan that speeds up again clears its bit
   always_comb
   begin
      life_alarm_status = 4'h0;
      life_alarm_status[plam_pkg::BIT_CTRL_CAP] =
         control_cap_life_percent < plam_pkg::PCT_CTRL_AL;
      life_alarm_status[plam_pkg::BIT_MAIN_CAP] =
         main_cap_life_percent <= plam_pkg::PCT_MAIN_AL;
      life_alarm_status[plam_pkg::BIT_FAN] =
         fan_fault_indication;
      life_alarm_status[plam_pkg::BIT_INRUSH] =
         inrush_life_percent <= plam_pkg::PCT_INRUSH_AL;
   end

   // Registered alarm outputs
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         fan_fault_indication <= 1'b0;
         life_alarm_output    <= 1'b0;
         alarm_prev_reg       <= 1'b0;
      end
      else
      begin
         fan_fault_indication <= fan_speed_percent <= (plam_pkg::PCT_FULL >> 1);
         life_alarm_output    <= |life_alarm_status;
         alarm_prev_reg       <= life_alarm_output;
      end
   end

   // Terminal routing, registered so the pins never glitch
   assign term_pos = {output_terminal_select_c == plam_pkg::SEL_POS,
                      output_terminal_select_b == plam_pkg::SEL_POS,
                      output_terminal_select_a == plam_pkg::SEL_POS};
   assign term_neg = {output_terminal_select_c == plam_pkg::SEL_NEG,
                      output_terminal_select_b == plam_pkg::SEL_NEG,
                      output_terminal_select_a == plam_pkg::SEL_NEG};

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         output_terminals <= 3'h0;
      else
         output_terminals <= (term_pos & {3{life_alarm_output}}) |
                             (term_neg & {3{~life_alarm_output}});
   end

   // Terminal select registers
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         output_terminal_select_a <= plam_pkg::TERM_SEL_RST;
         output_terminal_select_b <= plam_pkg::TERM_SEL_RST;
         output_terminal_select_c <= plam_pkg::TERM_SEL_RST;
      end
      else if (wr_acc && avs_byteenable[0])
      begin
         if (avs_address == plam_pkg::OFF_TERM_SEL_A)
            output_terminal_select_a <= avs_writedata[7:0];
         if (avs_address == plam_pkg::OFF_TERM_SEL_B)
            output_terminal_select_b <= avs_writedata[7:0];
         if (avs_address == plam_pkg::OFF_TERM_SEL_C)
            output_terminal_select_c <= avs_writedata[7:0];
      end
   end

   // Interrupts: set wins over a same-cycle clear
   assign irq_event[plam_pkg::EV_ALARM]     = life_alarm_output && !alarm_prev_reg;
   assign irq_event[plam_pkg::EV_MEAS_DONE] = meas_done;
   assign irq_event[plam_pkg::EV_MEAS_BAD]  = (state_reg == plam_pkg::PLAM_ST_MEAS) &&
                                              (run_command || output_shutoff_input ||
                                               ((dc_cnt_reg != 28'h0000000) && !motor_ok &&
                                                !power_on_event));

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         irq_status_reg <= 3'h0;
      else if (wr_acc && avs_address == plam_pkg::OFF_IRQ_CLEAR && avs_byteenable[0])
         irq_status_reg <= (irq_status_reg & ~avs_writedata[2:0]) | irq_event;
      else
         irq_status_reg <= irq_status_reg | irq_event;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         irq_enable_reg <= plam_pkg::IRQ_EN_RST;
      else if (wr_acc && avs_address == plam_pkg::OFF_IRQ_ENABLE && avs_byteenable[0])
         irq_enable_reg <= avs_writedata[2:0];
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   // Read data register; unmapped addresses read zero
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         avs_readdata <= 32'h00000000;
      else if (avs_read && !rd_pending_reg)
      begin
         case (avs_address)
            plam_pkg::OFF_STATUS:     avs_readdata <= {28'h0000000, life_alarm_status};
            plam_pkg::OFF_INRUSH:     avs_readdata <= {25'h0, inrush_life_percent};
            plam_pkg::OFF_CTRL_CAP:   avs_readdata <= {25'h0, control_cap_life_percent};
            plam_pkg::OFF_MAIN_CAP:   avs_readdata <= {25'h0, main_cap_life_percent};
            plam_pkg::OFF_MEAS_STATE: avs_readdata <= {28'h0000000, capacitor_measure_state};
            plam_pkg::OFF_TERM_SEL_A: avs_readdata <= {24'h000000, output_terminal_select_a};
            plam_pkg::OFF_TERM_SEL_B: avs_readdata <= {24'h000000, output_terminal_select_b};
            plam_pkg::OFF_TERM_SEL_C: avs_readdata <= {24'h000000, output_terminal_select_c};
            plam_pkg::OFF_INRUSH_CNT: avs_readdata <= {12'h000, inrush_cnt_reg};
            plam_pkg::OFF_IRQ_STATUS: avs_readdata <= {29'h0, irq_status_reg};
            plam_pkg::OFF_IRQ_ENABLE: avs_readdata <= {29'h0, irq_enable_reg};
            plam_pkg::OFF_IRQ_CLEAR:  avs_readdata <= 32'h00000000; // Write-only
            default:                  avs_readdata <= 32'h00000000;
         endcase
      end
   end

endmodule : plam_monitor

// ### bench/plam_monitor_checker.sv
// Port-level assertions for the part life alarm monitor
`timescale 1ns/1ps
module plam_monitor_checker
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rstn,
   // Register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Inverter events and levels
   input wire logic        power_on_event,
   input wire logic        power_off_event,
   input wire logic        run_command,
   input wire logic        output_shutoff_input,
   input wire logic        motor_ok,
   input wire logic [6:0]  fan_speed_percent,
   // Outputs
   input wire logic        life_alarm_output,
   input wire logic        fan_fault_indication,
   input wire logic        dc_inject
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // Length of the current injection, so its last cycle may end it
   logic [27:0] dc_len;
   always_ff @(posedge core_clk)
      dc_len <= dc_inject ? dc_len + 28'h0000001 : 28'h0000000;

   // Any cause but a restart write that must cut the injection short
   sequence dc_abort_s;
      dc_inject && (power_on_event || run_command || output_shutoff_input || !motor_ok);
   endsequence
   sequence read_wait_s;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence

   write_no_wait_a : assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   read_one_wait_a : assert property ($rose(avs_read) |-> read_wait_s)
      else $error("read wait not one cycle");
   readdata_hold_a : assert property (!$past(avs_read) && !avs_read |-> $stable(avs_readdata))
      else $error("read data moved without a read");
   dc_start_a : assert property ($rose(dc_inject) |-> $past(power_off_event))
      else $error("injection began without power-off");
   dc_abort_a : assert property (dc_abort_s |=> !dc_inject)
      else $error("injection kept after abort cause");
   dc_hold_a : assert property (dc_inject && motor_ok && !power_on_event && !run_command
      && !output_shutoff_input && !avs_write
      && dc_len != 28'(plam_pkg::DC_CYCLES - 1) |=> dc_inject)
      else $error("injection dropped early");
   // Registered flag, so the figure is last cycle's speed
   fan_fault_a : assert property ($past(rstn) |->
      fan_fault_indication == ($past(fan_speed_percent) <= 7'h32))
      else $error("fan fault flag wrong");
   fan_alarm_a : assert property (fan_fault_indication |-> ##[0:2] life_alarm_output)
      else $error("fan fault without life alarm");
endmodule : plam_monitor_checker

bind plam_monitor plam_monitor_checker u_chk
(
   .core_clk(core_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .power_on_event(power_on_event), .power_off_event(power_off_event),
   .run_command(run_command), .output_shutoff_input(output_shutoff_input),
   .motor_ok(motor_ok), .fan_speed_percent(fan_speed_percent),
   .life_alarm_output(life_alarm_output), .fan_fault_indication(fan_fault_indication),
   .dc_inject(dc_inject)
);

// ### bench/tb.sv
// Self-checking testbench for the part life alarm monitor
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
   logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest, cap_result_valid;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  ev;
   logic        operating, run_command, output_shutoff_input, trip_active, motor_ok;
   logic        ctrl_cap_wear_tick, life_alarm_output, fan_fault_indication, dc_inject, irq;
   logic [6:0]  fan_speed_percent, cap_result_percent;
   logic [2:0]  output_terminals;
   int          err_count, tests_run, cycles;

   plam_monitor uut
   (
      .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .power_on_event(ev[0]), .undervoltage_event(ev[1]), .inverter_reset_event(ev[2]),
      .power_off_event(ev[3]), .operating(operating), .run_command(run_command),
      .output_shutoff_input(output_shutoff_input), .trip_active(trip_active),
      .motor_ok(motor_ok), .ctrl_cap_wear_tick(ctrl_cap_wear_tick),
      .cap_result_valid(cap_result_valid), .cap_result_percent(cap_result_percent),
      .fan_speed_percent(fan_speed_percent), .life_alarm_output(life_alarm_output),
      .fan_fault_indication(fan_fault_indication), .dc_inject(dc_inject),
      .output_terminals(output_terminals), .irq(irq)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task end_of_test;
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // Starts one cycle late so request and release never share a time step
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd_chk

   // Registered outputs get a few cycles, then are read mid-cycle
   task settle;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   task fan_to(input logic [6:0] v);
      @(posedge core_clk);
      fan_speed_percent <= v;
      settle();
   endtask : fan_to

   task pulse(input int b);
      @(posedge core_clk);
      ev[b] <= 1'b1;
      @(posedge core_clk);
      ev[b] <= 1'b0;
   endtask : pulse

   task ticks(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         ctrl_cap_wear_tick <= 1'b1;
         @(posedge core_clk);
         ctrl_cap_wear_tick <= 1'b0;
      end
   endtask : ticks

   task t_reset;
      `CHK(life_alarm_output, 1'b0)
      rd_chk(plam_pkg::OFF_INRUSH, 32'h64);
      rd_chk(plam_pkg::OFF_CTRL_CAP, 32'h64);
      rd_chk(plam_pkg::OFF_MAIN_CAP, 32'h64);
      rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h0);
      rd_chk(8'h40, 32'h0);
      wr(plam_pkg::OFF_STATUS, 32'hf);
      rd_chk(plam_pkg::OFF_STATUS, 32'h0);
   endtask : t_reset

   task t_fan;
      fan_to(7'h32);
      `CHK(fan_fault_indication, 1'b1)
      `CHK(life_alarm_output, 1'b1)
      rd_chk(plam_pkg::OFF_STATUS, 32'h1 << plam_pkg::BIT_FAN);
      fan_to(7'h33);
      `CHK(fan_fault_indication, 1'b0)
      `CHK(life_alarm_output, 1'b0)
   endtask : t_fan

   task t_terms;
      logic [7:0] a;
      for (int i = 0; i < 3; i++)
      begin
         a = plam_pkg::OFF_TERM_SEL_A + 8'(4 * i);
         wr(a, 32'(plam_pkg::SEL_NEG));
         settle();
         `CHK(output_terminals, 3'h1 << i)
         fan_to(7'h28);
         `CHK(output_terminals, 3'h0)
         wr(a, 32'(plam_pkg::SEL_POS));
         rd_chk(a, 32'h5a);
         settle();
         `CHK(output_terminals, 3'h1 << i)
         wr(a, 32'h0);
         fan_to(7'h64);
      end
   endtask : t_terms

   task t_irq;
      wr(plam_pkg::OFF_IRQ_ENABLE, 32'h1 << plam_pkg::EV_ALARM);
      wr(plam_pkg::OFF_IRQ_CLEAR, 32'h7);
      settle();
      `CHK(irq, 1'b0)
      fan_to(7'h28);
      `CHK(irq, 1'b1)
      rd_chk(plam_pkg::OFF_IRQ_STATUS, 32'h1 << plam_pkg::EV_ALARM);
      wr(plam_pkg::OFF_IRQ_CLEAR, 32'h1 << plam_pkg::EV_ALARM);
      settle();
      `CHK(irq, 1'b0)
      wr(plam_pkg::OFF_IRQ_ENABLE, 32'h0);
      fan_to(7'h64);
      fan_to(7'h28);
      `CHK(irq, 1'b0)
      wr(plam_pkg::OFF_IRQ_ENABLE, 32'h1 << plam_pkg::EV_ALARM);
      settle();
      `CHK(irq, 1'b1)
      wr(plam_pkg::OFF_IRQ_CLEAR, 32'h1 << plam_pkg::EV_ALARM);
      fan_to(7'h64);
      `CHK(irq, 1'b0)
   endtask : t_irq

   task t_inrush;
      for (int i = 0; i < 9999; i++)
         pulse(i % 3);
      rd_chk(plam_pkg::OFF_INRUSH_CNT, 32'h270f);
      rd_chk(plam_pkg::OFF_INRUSH, 32'h64);
      pulse(0);
      rd_chk(plam_pkg::OFF_INRUSH, 32'h63);
   endtask : t_inrush

   task t_meas;
      logic [3:0] exp_code [4];
      exp_code = '{4'h8, 4'h8, 4'h9, 4'h2};
      wr(plam_pkg::OFF_MEAS_STATE, 32'h1);
      wr(plam_pkg::OFF_MEAS_STATE, 32'h3);
      wr(plam_pkg::OFF_MEAS_STATE, 32'h8);
      rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h1);
      @(posedge core_clk);
      trip_active <= 1'b1;
      pulse(3);
      trip_active <= 1'b0;
      @(negedge core_clk);
      `CHK(dc_inject, 1'b0)
      rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         wr(plam_pkg::OFF_MEAS_STATE, 32'h0);
         wr(plam_pkg::OFF_MEAS_STATE, 32'h1);
         pulse(3);
         @(negedge core_clk);
         `CHK(dc_inject, 1'b1)
         rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h2);
         @(posedge core_clk);
         case (i)
            0: run_command <= 1'b1;
            1: output_shutoff_input <= 1'b1;
            2: motor_ok <= 1'b0;
            default: ev[0] <= 1'b1;
         endcase
         @(posedge core_clk);
         {run_command, output_shutoff_input, motor_ok, ev[0]} <= 4'b0010;
         @(negedge core_clk);
         `CHK(dc_inject, 1'b0)
         rd_chk(plam_pkg::OFF_MEAS_STATE, 32'(exp_code[i]));
      end
      wr(plam_pkg::OFF_MEAS_STATE, 32'h1);
      rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h1);
   endtask : t_meas

   task t_ctrl;
      ticks(5);
      rd_chk(plam_pkg::OFF_CTRL_CAP, 32'h64);
      operating <= 1'b1;
      ticks(90);
      rd_chk(plam_pkg::OFF_CTRL_CAP, 32'h0a);
      rd_chk(plam_pkg::OFF_STATUS, 32'h0);
      ticks(1);
      rd_chk(plam_pkg::OFF_STATUS, 32'h1 << plam_pkg::BIT_CTRL_CAP);
      `CHK(life_alarm_output, 1'b1)
      ticks(20);
      rd_chk(plam_pkg::OFF_CTRL_CAP, 32'h0);
   endtask : t_ctrl

   // Injection cut by power return, then the result arrives
   task t_done(input logic [6:0] pct, input logic [31:0] st);
      wr(plam_pkg::OFF_IRQ_CLEAR, 32'h7);
      wr(plam_pkg::OFF_MEAS_STATE, 32'h1);
      pulse(3);
      pulse(0);
      @(posedge core_clk);
      {cap_result_valid, cap_result_percent} <= {1'b1, pct};
      @(posedge core_clk);
      cap_result_valid <= 1'b0;
      rd_chk(plam_pkg::OFF_MEAS_STATE, 32'h3);
      rd_chk(plam_pkg::OFF_MAIN_CAP, 32'(pct));
      rd_chk(plam_pkg::OFF_STATUS, st);
      rd_chk(plam_pkg::OFF_IRQ_STATUS, 32'h1 << plam_pkg::EV_MEAS_DONE);
   endtask : t_done

   // Hang guard, well above the inrush sweep of about 20,000 cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         err_count++;
         end_of_test();
      end
   end

   initial
   begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata, ev} = '0;
      {operating, run_command, output_shutoff_input, trip_active} = 4'h0;
      {ctrl_cap_wear_tick, motor_ok, fan_speed_percent} = {1'b0, 1'b1, 7'h64};
      {cap_result_valid, cap_result_percent} = '0;
      {err_count, tests_run, cycles} = '0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_fan();
      t_terms();
      t_irq();
      t_inrush();
      t_meas();
      t_ctrl();
      t_done(7'h56, 32'h1);
      t_done(7'h55, 32'h3);
      end_of_test();
   end
endmodule : tb
